// ### design/hsmc_home_search.sv
// home search mode parameters and their application to one axis
// assumes search inputs active high after level config, counters outside
module hsmc_home_search
    import hsmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [15:0] writeData,
    input wire logic [7:0] cmdCode,
    input wire logic cmdStrobe,
    input wire logic searchStart,
    input wire logic stepDone,
    input wire logic stopInputZero,
    input wire logic stopInputOne,
    input wire logic stopInputTwo,
    input wire logic limitPlus,
    input wire logic limitMinus,
    output logic [15:0] homeStepParams,
    output logic [15:0] homeStopTimerParams,
    output logic [2:0] activeStep,
    output logic driveMinus,
    output logic driveRun,
    output logic deviationClearOutput,
    output logic realCounterClear,
    output logic logicalCounterClear,
    output logic searchBusy
);
    hsmc_state_t state_reg;
    hsmc_state_t retState_reg;
    logic [15:0] step_reg;
    logic [15:0] stopTmr_reg;
    logic [4:0] pinMeta_reg, pinSync_reg;
    logic s2Prev_reg;
    logic [CNT_W-1:0] pulseCnt_reg;
    logic [CNT_W-1:0] waitCnt_reg;
    logic pulseOn_reg;
    logic detect;
    logic [2:0] nextStep;
    logic s0, s1, s2, lp, lm;

    function automatic logic [CNT_W-1:0] usToCycles(input int us);
        int c;
        c = us * CYC_PER_US;
        if (c < 1)
        begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction

    // pick limit for a direction
    function automatic logic limitFor(input logic dirMinus, input logic p, input logic m);
        return dirMinus ? m : p;
    endfunction

    assign {lm, lp, s2, s1, s0} = pinSync_reg;

    // parameter writes
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            step_reg <= PARAMS_RESET;
            stopTmr_reg <= PARAMS_RESET;
        end
        else if (cmdStrobe)
        begin
            if (cmdCode == CMD_STEP_PARAMS)
            begin
                step_reg <= writeData;
            end
            else if (cmdCode == CMD_STOP_TIMER_PARAMS)
            begin
                stopTmr_reg <= writeData;
            end
        end
    end

    // input synchronisers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pinMeta_reg <= 5'h00;
            pinSync_reg <= 5'h00;
            s2Prev_reg <= 1'b0;
        end
        else
        begin
            pinMeta_reg <= {limitMinus, limitPlus, stopInputTwo, stopInputOne, stopInputZero};
            pinSync_reg <= pinMeta_reg;
            s2Prev_reg <= s2;
        end
    end

    // detection per step
    always_comb
    begin
        detect = 1'b0;
        case (state_reg)
            HSMC_STEP1:
            begin
                case (step_reg[B_S1_SIG +: 2])
                    2'b00: detect = s0;
                    2'b01: detect = s1;
                    2'b10: detect = limitFor(step_reg[B_S1_DIR], lp, lm);
                    default: detect = 1'b0;
                endcase
            end
            HSMC_STEP2:
            begin
                if (step_reg[B_S2_SIG])
                begin
                    detect = limitFor(step_reg[B_S2_DIR], lp, lm);
                end
                else
                begin
                    detect = s1;
                end
            end
            HSMC_STEP3:
            begin
                if (stopTmr_reg[B_SAND] && !step_reg[B_S2_SIG])
                begin
                    detect = s2 && !s2Prev_reg && s1;
                end
                else
                begin
                    detect = s2 && !s2Prev_reg;
                end
            end
            HSMC_STEP4:
            begin
                detect = stepDone;
            end
            default: detect = 1'b0;
        endcase
    end

    // first enabled step at or after a given one
    function automatic logic [2:0] firstFrom(input logic [2:0] from, input logic [15:0] p);
        logic [2:0] r;
        r = 3'd0;
        if (from <= 3'd1 && p[B_S1_EN])
        begin
            r = 3'd1;
        end
        else if (from <= 3'd2 && p[B_S2_EN])
        begin
            r = 3'd2;
        end
        else if (from <= 3'd3 && p[B_S3_EN])
        begin
            r = 3'd3;
        end
        else if (from <= 3'd4 && p[B_S4_EN])
        begin
            r = 3'd4;
        end
        return r;
    endfunction

    assign nextStep = firstFrom(3'(state_reg) + 3'd1, step_reg);

    function automatic hsmc_state_t toState(input logic [2:0] s);
        hsmc_state_t t;
        case (s)
            3'd1: t = HSMC_STEP1;
            3'd2: t = HSMC_STEP2;
            3'd3: t = HSMC_STEP3;
            3'd4: t = HSMC_STEP4;
            default: t = HSMC_IDLE;
        endcase
        return t;
    endfunction

    // step sequencer
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= HSMC_IDLE;
            retState_reg <= HSMC_IDLE;
            waitCnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                HSMC_IDLE:
                begin
                    if (searchStart)
                    begin
                        state_reg <= toState(firstFrom(3'd1, step_reg));
                    end
                end
                HSMC_STEP1, HSMC_STEP2, HSMC_STEP3, HSMC_STEP4:
                begin
                    if (detect)
                    begin
                        if (stopTmr_reg[B_TMR_EN] && nextStep != 3'd0)
                        begin
                            retState_reg <= toState(nextStep);
                            waitCnt_reg <= usToCycles(TMR_US[stopTmr_reg[B_TMR +: 3]]);
                            state_reg <= HSMC_WAIT;
                        end
                        else
                        begin
                            state_reg <= toState(nextStep);
                        end
                    end
                end
                HSMC_WAIT:
                begin
                    if (waitCnt_reg <= CNT_W'(1))
                    begin
                        state_reg <= retState_reg;
                    end
                    else
                    begin
                        waitCnt_reg <= waitCnt_reg - CNT_W'(1);
                    end
                end
                default: state_reg <= HSMC_IDLE;
            endcase
        end
    end

    // clear pulse and counter clears
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pulseOn_reg <= 1'b0;
            pulseCnt_reg <= '0;
            realCounterClear <= 1'b0;
            logicalCounterClear <= 1'b0;
        end
        else
        begin
            realCounterClear <= 1'b0;
            logicalCounterClear <= 1'b0;
            if (detect && state_reg == HSMC_STEP2)
            begin
                realCounterClear <= step_reg[B_S2_RC];
                logicalCounterClear <= step_reg[B_S2_LC];
            end
            else if (detect && state_reg == HSMC_STEP3)
            begin
                realCounterClear <= step_reg[B_S3_RC];
                logicalCounterClear <= step_reg[B_S3_LC];
            end
            if (detect && nextStep == 3'd0 && stopTmr_reg[B_END_RC])
                realCounterClear <= 1'b1;
            if (detect && nextStep == 3'd0 && stopTmr_reg[B_END_LC])
                logicalCounterClear <= 1'b1;
            if (detect && ((state_reg == HSMC_STEP2 && step_reg[B_S2_DCC])
                || (state_reg == HSMC_STEP3 && step_reg[B_S3_DCC])))
            begin
                pulseOn_reg <= 1'b1;
                pulseCnt_reg <= usToCycles(PW_US[stopTmr_reg[B_PW +: 3]]);
            end
            else if (pulseOn_reg)
            begin
                if (pulseCnt_reg <= CNT_W'(1))
                begin
                    pulseOn_reg <= 1'b0;
                end
                pulseCnt_reg <= pulseCnt_reg - CNT_W'(1);
            end
        end
    end

    // registered outputs
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            homeStepParams <= PARAMS_RESET;
            homeStopTimerParams <= PARAMS_RESET;
            activeStep <= 3'h0;
            driveMinus <= 1'b0;
            driveRun <= 1'b0;
            deviationClearOutput <= 1'b0;
            searchBusy <= 1'b0;
        end
        else
        begin
            homeStepParams <= step_reg;
            homeStopTimerParams <= stopTmr_reg;
            activeStep <= (state_reg == HSMC_WAIT) ? 3'h0 : 3'(state_reg);
            driveRun <= state_reg != HSMC_IDLE && state_reg != HSMC_WAIT;
            searchBusy <= state_reg != HSMC_IDLE;
            deviationClearOutput <= pulseOn_reg ^ stopTmr_reg[B_POL];
            case (state_reg)
                HSMC_STEP1: driveMinus <= step_reg[B_S1_DIR];
                HSMC_STEP2: driveMinus <= step_reg[B_S2_DIR];
                HSMC_STEP3: driveMinus <= step_reg[B_S3_DIR];
                default: driveMinus <= 1'b0;
            endcase
        end
    end

    a_reset_zero: assert property (@(posedge core_clk) $rose(nrst)
        |-> step_reg == 16'h0000 && stopTmr_reg == 16'h0000)
        else $error("parameters not zero after reset");
    a_write_step: assert property (@(posedge core_clk) disable iff (!nrst)
        cmdStrobe && cmdCode == CMD_STEP_PARAMS |=> step_reg == $past(writeData))
        else $error("step parameter write lost");
    a_skip_step1: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == HSMC_IDLE && searchStart && !step_reg[0] |=> state_reg != HSMC_STEP1)
        else $error("disabled step one entered");
    a_skip_step2: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == HSMC_STEP2 |-> step_reg[4])
        else $error("disabled step two running");
    a_skip_step3: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == HSMC_STEP3 |-> step_reg[10])
        else $error("disabled step three running");
    a_skip_step4: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == HSMC_STEP4 |-> step_reg[15])
        else $error("disabled step four running");
    a_dir_step1: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == HSMC_STEP1 |=> driveMinus == $past(step_reg[1]))
        else $error("step one direction wrong");
    a_sand_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == HSMC_STEP3 && stopTmr_reg[0] && !step_reg[6] && !s1
        |-> !detect)
        else $error("stop-and ignored");
    a_pulse_pol: assert property (@(posedge core_clk) disable iff (!nrst)
        !pulseOn_reg && !$rose(nrst) ##1 !$changed(stopTmr_reg[3])
        |-> deviationClearOutput == stopTmr_reg[3])
        else $error("clear pulse idle level wrong");
    a_pulse_width: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(pulseOn_reg) && stopTmr_reg[6:4] == 3'd0 |-> pulseOn_reg [*8])
        else $error("clear pulse too short");
    a_no_timer: assert property (@(posedge core_clk) disable iff (!nrst)
        !stopTmr_reg[7] && state_reg != HSMC_WAIT |=> state_reg != HSMC_WAIT)
        else $error("wait without timer enable");
    a_step2_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == HSMC_STEP2 && detect && step_reg[8] |=> realCounterClear)
        else $error("step two real clear missing");

    c_full_search: cover property (@(posedge core_clk) state_reg == HSMC_STEP4 && detect);
    c_wait_used: cover property (@(posedge core_clk) state_reg == HSMC_WAIT);
    c_pulse: cover property (@(posedge core_clk) $fell(pulseOn_reg));
endmodule

// ### design/hsmc_pkg.sv
// package for the home search mode configuration block
// assumes a single 10 MHz core clock and an 8-bit command interface
package hsmc_pkg;
    // cycle counts as at a 16 MHz clock, times scale with the core clock
    localparam int TABLE_CLK_HZ = 16_000_000;
    localparam logic [7:0] CMD_STEP_PARAMS = 8'h23;
    localparam logic [7:0] CMD_STOP_TIMER_PARAMS = 8'h24;
    localparam logic [15:0] PARAMS_RESET = 16'h0000;
    // first parameter bit positions
    localparam int B_S1_EN = 0;
    localparam int B_S1_DIR = 1;
    localparam int B_S1_SIG = 2;
    localparam int B_S2_EN = 4;
    localparam int B_S2_DIR = 5;
    localparam int B_S2_SIG = 6;
    localparam int B_S2_DCC = 7;
    localparam int B_S2_RC = 8;
    localparam int B_S2_LC = 9;
    localparam int B_S3_EN = 10;
    localparam int B_S3_DIR = 11;
    localparam int B_S3_DCC = 12;
    localparam int B_S3_RC = 13;
    localparam int B_S3_LC = 14;
    localparam int B_S4_EN = 15;
    // second parameter bit positions
    localparam int B_SAND = 0;
    localparam int B_END_RC = 1;
    localparam int B_END_LC = 2;
    localparam int B_POL = 3;
    localparam int B_PW = 4;
    localparam int B_TMR_EN = 7;
    localparam int B_TMR = 8;
    localparam int B_H2_USED = 11;
    // times in microseconds
    localparam int PW_US [8] = '{10, 20, 100, 200, 1000, 2000, 10000, 20000};
    localparam int TMR_US [8] = '{1000, 2000, 10000, 20000, 100000, 200000, 500000,
        1000000};
    localparam int CYC_PER_US = TABLE_CLK_HZ / 1_000_000;
    localparam int CNT_W = 24;
    typedef enum logic [2:0] {
        HSMC_IDLE = 3'b000,
        HSMC_STEP1 = 3'b001,
        HSMC_STEP2 = 3'b010,
        HSMC_STEP3 = 3'b011,
        HSMC_STEP4 = 3'b100,
        HSMC_WAIT = 3'b101
    } hsmc_state_t;
endpackage

// ### sim/hsmc_host_model.sv
// host model issuing parameter write commands
// assumes the bench calls write_param, one core clock, no reset of its own
module hsmc_host_model
    import hsmc_pkg::*;
(
    input wire logic core_clk,
    output logic [15:0] writeData,
    output logic [7:0] cmdCode,
    output logic cmdStrobe
);
    timeunit 1ns;
    timeprecision 1ns;
    // search input levels are taken as already set active high
    initial
    begin
        writeData = 16'h0000;
        cmdCode = 8'h00;
        cmdStrobe = 1'b0;
    end
    // data and code with a one-cycle strobe, then released inverted
    task automatic write_param(input logic [7:0] code, input logic [15:0] data);
        logic [15:0] word;
        word = data;
        if (code === CMD_STOP_TIMER_PARAMS)
        begin
            word[15:11] = 5'h00;
        end
        @(negedge core_clk);
        writeData = word;
        cmdCode = code;
        cmdStrobe = 1'b1;
        @(negedge core_clk);
        cmdStrobe = 1'b0;
        writeData = ~word;
        cmdCode = ~code;
    endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the home search mode block
// assumes host model on the command port, bench drives pins and step done
module tb
    import hsmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, nrst, searchStart, stepDone;
    logic stopInputZero, stopInputOne, stopInputTwo, limitPlus, limitMinus;
    logic [15:0] writeData, homeStepParams, homeStopTimerParams;
    logic [7:0] cmdCode;
    logic cmdStrobe, driveMinus, driveRun, deviationClearOutput;
    logic realCounterClear, logicalCounterClear, searchBusy;
    logic [2:0] activeStep;
    logic [15:0] rcCnt = 16'h0000;
    logic [15:0] lcCnt = 16'h0000;
    logic [15:0] rc0, lc0;
    logic [15:0] h1v [5] = '{16'h0001, 16'h0005, 16'h0009, 16'h000D, 16'h000B};
    logic [4:0] selv [5] = '{5'h01, 5'h02, 5'h08, 5'h00, 5'h10};
    int failCount = 0;
    int samplesChecked = 0;
    int i, w;
    hsmc_host_model i_host (.core_clk(core_clk), .writeData(writeData),
        .cmdCode(cmdCode), .cmdStrobe(cmdStrobe));
    hsmc_home_search i_dut (.core_clk(core_clk), .nrst(nrst), .writeData(writeData),
        .cmdCode(cmdCode), .cmdStrobe(cmdStrobe), .searchStart(searchStart),
        .stepDone(stepDone), .stopInputZero(stopInputZero),
        .stopInputOne(stopInputOne), .stopInputTwo(stopInputTwo),
        .limitPlus(limitPlus), .limitMinus(limitMinus),
        .homeStepParams(homeStepParams), .homeStopTimerParams(homeStopTimerParams),
        .activeStep(activeStep), .driveMinus(driveMinus), .driveRun(driveRun),
        .deviationClearOutput(deviationClearOutput),
        .realCounterClear(realCounterClear), .logicalCounterClear(logicalCounterClear),
        .searchBusy(searchBusy));
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        if (realCounterClear === 1'b1)
            rcCnt <= rcCnt + 16'h0001;
        if (logicalCounterClear === 1'b1)
            lcCnt <= lcCnt + 16'h0001;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            failCount++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic closeOut();
        if (failCount == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rst();
        nrst = 1'b0;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
    endtask
    task automatic pins(input logic [4:0] v);
        {limitMinus, limitPlus, stopInputTwo, stopInputOne, stopInputZero} = v;
    endtask
    task automatic cfg(input logic [15:0] h1, input logic [15:0] h2);
        i_host.write_param(CMD_STEP_PARAMS, h1);
        i_host.write_param(CMD_STOP_TIMER_PARAMS, h2);
        repeat (2) @(negedge core_clk);
        chk(homeStepParams, h1);
        chk(homeStopTimerParams, h2);
        rc0 = rcCnt;
        lc0 = lcCnt;
    endtask
    task automatic go();
        searchStart = 1'b1;
        @(negedge core_clk);
        searchStart = 1'b0;
    endtask
    task automatic wstep(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (activeStep !== s && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        chk(activeStep, s);
    endtask
    task automatic widle(input int lim);
        int n;
        n = 0;
        while (searchBusy !== 1'b0 && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        chk(searchBusy, 1'b0);
    endtask
    task automatic pw(input logic lvl, output int width);
        int n;
        n = 0;
        width = 0;
        while (deviationClearOutput !== lvl && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        while (deviationClearOutput === lvl && width < 1000)
        begin
            @(negedge core_clk);
            width++;
        end
    endtask
    task automatic stay(input logic [2:0] s);
        repeat (8) @(negedge core_clk);
        chk(activeStep, s);
    endtask
    initial
    begin
        nrst = 1'b0;
        searchStart = 1'b0;
        stepDone = 1'b0;
        pins(5'h00);
        rst();
        chk(homeStepParams, 16'h0000);
        chk(homeStopTimerParams, 16'h0000);
        chk(searchBusy, 1'b0);
        i_host.write_param(8'h25, 16'hFFFF);
        repeat (2) @(negedge core_clk);
        chk(homeStepParams, 16'h0000);
        // step one: every signal code, both limit directions
        for (i = 0; i < 5; i++)
        begin
            cfg(h1v[i], 16'h0006);
            go();
            wstep(3'h1, 10);
            chk(driveMinus, i == 4);
            chk(driveRun, 1'b1);
            pins(5'h1B & ~selv[i]);
            stay(3'h1);
            pins(5'h1B);
            if (i == 3)
            begin
                stay(3'h1);
                rst();
                chk(homeStepParams, 16'h0000);
            end
            else
            begin
                widle(10);
                chk(rcCnt, rc0 + 16'h0001);
                chk(lcCnt, lc0 + 16'h0001);
            end
            pins(5'h00);
        end
        // step two on stop one, negative clear pulse, both clears
        cfg(16'h0390, 16'h0008);
        chk(deviationClearOutput, 1'b1);
        go();
        wstep(3'h2, 10);
        pins(5'h08);
        stay(3'h2);
        pins(5'h0A);
        pw(1'b0, w);
        chk(w, PW_US[0] * CYC_PER_US);
        chk(rcCnt, rc0 + 16'h0001);
        chk(lcCnt, lc0 + 16'h0001);
        widle(10);
        pins(5'h00);
        // step two on minus limit, no clears
        cfg(16'h0070, 16'h0000);
        go();
        wstep(3'h2, 10);
        chk(driveMinus, 1'b1);
        pins(5'h0B);
        stay(3'h2);
        pins(5'h1B);
        widle(10);
        chk(rcCnt, rc0);
        pins(5'h00);
        // step three with stop-and and step two on stop one
        cfg(16'h7400, 16'h0011);
        go();
        wstep(3'h3, 10);
        pins(5'h04);
        stay(3'h3);
        pins(5'h02);
        repeat (4) @(negedge core_clk);
        pins(5'h06);
        pw(1'b1, w);
        chk(w, PW_US[1] * CYC_PER_US);
        chk(rcCnt, rc0 + 16'h0001);
        chk(lcCnt, lc0 + 16'h0001);
        widle(10);
        pins(5'h00);
        // stop-and ignored when step two uses the limit
        cfg(16'h0C40, 16'h0001);
        go();
        wstep(3'h3, 10);
        chk(driveMinus, 1'b1);
        pins(5'h04);
        widle(10);
        pins(5'h00);
        // step four ends on step done
        cfg(16'h8000, 16'h0000);
        go();
        wstep(3'h4, 10);
        stay(3'h4);
        stepDone = 1'b1;
        widle(10);
        stepDone = 1'b0;
        // between-step timer off, then on with the shortest interval
        for (i = 0; i < 2; i++)
        begin
            cfg(16'h0011, (i == 1) ? 16'h0080 : 16'h0000);
            go();
            wstep(3'h1, 10);
            pins(5'h01);
            if (i == 1)
            begin
                wstep(3'h0, 10);
                w = 0;
                while (activeStep === 3'h0 && searchBusy === 1'b1 && w < 20000)
                begin
                    @(negedge core_clk);
                    w++;
                end
                chk(w > TMR_US[0] * CYC_PER_US - 10, 1'b1);
                chk(w < TMR_US[0] * CYC_PER_US + 10, 1'b1);
            end
            wstep(3'h2, 10);
            pins(5'h02);
            widle(10);
            pins(5'h00);
        end
        closeOut();
    end
    initial
    begin
        #5_000_000;
        failCount++;
        closeOut();
    end
endmodule
